// *** rtl/fec_regs.vh ***
// register offsets, field positions and reset values for the flash control block
`ifndef FEC_REGS_VH
`define FEC_REGS_VH
`define FEC_OFF_MODE     4'h0
`define FEC_OFF_STAT     4'h1
`define FEC_OFF_EBS      4'h2
`define FEC_OFF_ACC      4'h3
`define FEC_OFF_IRQ_STAT 4'h4
`define FEC_OFF_IRQ_MASK 4'h5
`define FEC_OFF_BOOT     4'h6
`define FEC_MODE_P       0
`define FEC_MODE_E       1
`define FEC_MODE_PV      2
`define FEC_MODE_EV      3
`define FEC_MODE_PSU     4
`define FEC_MODE_ESU     5
`define FEC_MODE_SWE     6
`define FEC_STAT_ERR     7
`define FEC_ACC_EN       7
`define FEC_EBS_MASK     8'h1F
`define FEC_MODE_MASK    8'h7F
`define FEC_RST8         8'h00
`define FEC_IRQ_ERR      0
`define FEC_IRQ_ERASE    1
`define FEC_IRQ_BOOT     2
`define FEC_IRQ_W        3
`endif

// *** rtl/fec_mode_sel.v ***
// reset-end operating mode capture from strap pins
`timescale 1ns/1ps
module fec_mode_sel (
	// clock and reset
	input  wire clk_i,
	input  wire rst_i,
	// strap pins
	input  wire test_i,
	input  wire nmi_i,
	input  wire timer_port_select_pin_i,
	// captured mode
	output reg  user_mode_o,
	output reg  boot_mode_o,
	output reg  done_o
);
	// capture once on the first edge after release; straps must already be stable
	always @(posedge clk_i) begin
		if (rst_i) begin
			user_mode_o <= 1'b0;
			boot_mode_o <= 1'b0;
			done_o      <= 1'b0;
		end else if (!done_o) begin
			done_o      <= 1'b1;
			user_mode_o <= !test_i && nmi_i;
			boot_mode_o <= !test_i && !nmi_i && timer_port_select_pin_i;
		end
	end
endmodule

// *** rtl/fec_boot_seq.v ***
// boot sequencer: program download then full erase, then release to loaded program
`timescale 1ns/1ps
module fec_boot_seq (
	// clock and reset
	input  wire clk_i,
	input  wire rst_i,
	// control
	input  wire start_i,
	input  wire load_done_i,
	input  wire erase_done_i,
	input  wire erase_fail_i,
	// status
	output reg  load_active_o,
	output reg  erase_all_o,
	output reg  run_o,
	output reg  abort_o
);
	localparam ST_IDLE  = 2'b00;
	localparam ST_LOAD  = 2'b01;
	localparam ST_ERASE = 2'b10;
	localparam ST_END   = 2'b11;
	reg [1:0] state_q; // sequencer state
	// load over serial channel, then erase everything, then run
	always @(posedge clk_i) begin
		if (rst_i) begin
			state_q       <= ST_IDLE;
			load_active_o <= 1'b0;
			erase_all_o   <= 1'b0;
			run_o         <= 1'b0;
			abort_o       <= 1'b0;
		end else begin
			case (state_q)
			ST_IDLE: begin
				if (start_i) begin
					state_q       <= ST_LOAD;
					load_active_o <= 1'b1;
				end
			end
			ST_LOAD: begin
				if (load_done_i) begin
					state_q       <= ST_ERASE;
					load_active_o <= 1'b0;
					erase_all_o   <= 1'b1;
				end
			end
			ST_ERASE: begin
				if (erase_fail_i) begin
					state_q     <= ST_END;
					erase_all_o <= 1'b0;
					abort_o     <= 1'b1;
				end else if (erase_done_i) begin
					state_q     <= ST_END;
					erase_all_o <= 1'b0;
					run_o       <= 1'b1;
				end
			end
			default: begin
				state_q <= ST_END; // held until reset
			end
			endcase
		end
	end
endmodule

// *** rtl/fec_top.v ***
// flash erase control, status, access gate and mode select top level
// Functional notes
// - status register is read only
// - error flag bit 7 sets on failure, protects
// - reserved bits always read zero
// - block select held zero while write enable clear
// - multiple block bits written clears whole register
// - bit 4 selects large block 1000-7FFF
// - bits 3..0 select four 1-kbyte blocks
// - access bit gates control register access
// - mode chosen from strap pins at reset end
// - boot mode downloads program over serial
// - boot erases all flash before running
// - user mode erases blocks individually
// - write enable clear refuses other bit sets unless the same write sets write enable
// - erase mode needs write enable and setup
`timescale 1ns/1ps
`include "fec_regs.vh"
module fec_top (
	// clock and reset
	input  wire        clk_i,
	input  wire        rst_i,
	// avalon-mm slave
	input  wire [3:0]  avs_address_i,
	input  wire        avs_read_i,
	input  wire        avs_write_i,
	input  wire [31:0] avs_writedata_i,
	input  wire [3:0]  avs_byteenable_i,
	output reg  [31:0] avs_readdata_o,
	output wire        avs_waitrequest_o,
	// strap pins
	input  wire        test_i,
	input  wire        nmi_i,
	input  wire        timer_port_select_pin_i,
	// flash array side
	input  wire        flash_fail_i,
	input  wire        flash_done_i,
	input  wire        boot_load_done_i,
	output wire        erase_mode_o,
	output wire        program_mode_o,
	output wire [4:0]  erase_sel_o,
	output wire        erase_all_o,
	output wire        boot_load_o,
	output wire        boot_run_o,
	output wire        user_mode_o,
	// interrupt
	output wire        irq_o
);
	reg  [6:0] flash_mode_control_q;   // program/erase mode bits
	reg        flash_error_flag_q;     // sticky error flag
	reg  [4:0] erase_block_select_q;   // one-hot erase region
	reg        ctrl_reg_access_bit_q;  // access gate
	reg  [2:0] irq_stat_q;             // sticky events
	reg  [2:0] irq_mask_q;             // interrupt mask
	reg        ack_q;                  // one wait cycle per access
	reg  [7:0] wdat;                   // low byte of write data
	wire       acc_wr;                 // write accepted this cycle
	wire       acc_rd;                 // read accepted this cycle
	wire       gated_ok;               // gated register reachable
	wire       software_write_enable;                    // software write enable
	wire       boot_mode;              // boot strap captured
	wire       mode_done;              // strap capture done
	wire       boot_abort;             // boot erase failed
	wire [2:0] ev;                     // event inputs; error and erase are pulses, boot is a level
	reg        erase_q;                // erase mode delayed, for done event
	wire [4:0] ebs_next;               // candidate block select
	wire       mode_wr;                // accepted write to mode control

	// test for more than one set bit, used to reject multi-bit selects
	function more_than_one;
		input [4:0] v;
		begin
			more_than_one = |(v & (v - 5'h01));
		end
	endfunction

	// write masked to low byte lane, others are ignored
	always @* begin
		wdat = avs_byteenable_i[0] ? avs_writedata_i[7:0] : 8'h00;
	end

	// each access waits exactly one cycle; waitrequest drops on the second
	assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_q;
	assign acc_wr   = avs_write_i && ack_q;
	assign acc_rd   = avs_read_i && ack_q;
	assign gated_ok = ctrl_reg_access_bit_q;
	assign software_write_enable      = flash_mode_control_q[`FEC_MODE_SWE];
	// same gating as the mode register process, error protection included
	assign mode_wr  = acc_wr && gated_ok && avs_byteenable_i[0]
		&& avs_address_i == `FEC_OFF_MODE && !flash_error_flag_q;

	// handshake pacing
	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= (avs_read_i || avs_write_i) && !ack_q;
		end
	end

	// mode control register; protected while write enable clear or error
	always @(posedge clk_i) begin
		if (rst_i) begin
			flash_mode_control_q <= 7'h00;
		end else if (flash_error_flag_q) begin
			flash_mode_control_q <= flash_mode_control_q & 7'h40;
		end else if (acc_wr && gated_ok && avs_byteenable_i[0]
			&& avs_address_i == `FEC_OFF_MODE) begin
			if (wdat[`FEC_MODE_SWE] || software_write_enable) begin
				flash_mode_control_q <= wdat[6:0];
			end else begin
				flash_mode_control_q <= 7'h00;
			end
		end
	end

	// erase and program enter only with setup bits and write enable
	assign erase_mode_o   = software_write_enable && flash_mode_control_q[`FEC_MODE_ESU]
		&& flash_mode_control_q[`FEC_MODE_E];
	assign program_mode_o = software_write_enable && flash_mode_control_q[`FEC_MODE_PSU]
		&& flash_mode_control_q[`FEC_MODE_P];

	// block select; multi-bit writes clear, forced zero without swe
	assign ebs_next = wdat[4:0];
	always @(posedge clk_i) begin
		if (rst_i) begin
			erase_block_select_q <= 5'h00;
		end else if (!software_write_enable || (mode_wr && !wdat[`FEC_MODE_SWE])) begin
			// cleared in the same edge as write enable, no stale select cycle
			erase_block_select_q <= 5'h00;
		end else if (acc_wr && gated_ok && avs_byteenable_i[0]
			&& avs_address_i == `FEC_OFF_EBS) begin
			if (more_than_one(ebs_next)) begin
				erase_block_select_q <= 5'h00;
			end else begin
				erase_block_select_q <= ebs_next;
			end
		end
	end
	// bit 4 large block, bits 3..0 the small blocks
	assign erase_sel_o = erase_block_select_q;

	// error flag: hardware only, writes have no effect
	always @(posedge clk_i) begin
		if (rst_i) begin
			flash_error_flag_q <= 1'b0;
		end else if (flash_fail_i && (erase_mode_o || program_mode_o || erase_all_o)) begin
			flash_error_flag_q <= 1'b1;
		end
	end

	// access enable register, always reachable
	always @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_reg_access_bit_q <= 1'b0;
		end else if (acc_wr && avs_byteenable_i[0] && avs_address_i == `FEC_OFF_ACC) begin
			ctrl_reg_access_bit_q <= wdat[`FEC_ACC_EN];
		end
	end

	// events: error set, erase finished, boot program released
	always @(posedge clk_i) begin
		if (rst_i) begin
			erase_q <= 1'b0;
		end else begin
			erase_q <= erase_mode_o;
		end
	end
	assign ev[`FEC_IRQ_ERR]   = flash_fail_i && !flash_error_flag_q
		&& (erase_mode_o || program_mode_o || erase_all_o);
	assign ev[`FEC_IRQ_ERASE] = erase_q && !erase_mode_o;
	assign ev[`FEC_IRQ_BOOT]  = boot_run_o;

	// sticky status, write one to clear; a new event wins over clear
	always @(posedge clk_i) begin
		if (rst_i) begin
			irq_stat_q <= 3'h0;
			irq_mask_q <= 3'h0;
		end else begin
			if (acc_wr && avs_byteenable_i[0] && avs_address_i == `FEC_OFF_IRQ_STAT) begin
				irq_stat_q <= (irq_stat_q & ~wdat[2:0]) | ev;
			end else begin
				irq_stat_q <= irq_stat_q | ev;
			end
			if (acc_wr && avs_byteenable_i[0] && avs_address_i == `FEC_OFF_IRQ_MASK) begin
				irq_mask_q <= wdat[2:0];
			end
		end
	end
	assign irq_o = |(irq_stat_q & irq_mask_q);

	// read mux; loaded on the first edge of a read so data stand while waitrequest is low
	// reserved bits and unmapped addresses read zero; data hold until the next read
	always @(posedge clk_i) begin
		if (rst_i) begin
			avs_readdata_o <= 32'h00000000;
		end else if (avs_read_i && !ack_q) begin
			avs_readdata_o <= 32'h00000000;
			if (avs_address_i == `FEC_OFF_MODE) begin
				if (gated_ok) begin
					avs_readdata_o[6:0] <= flash_mode_control_q;
				end
			end else if (avs_address_i == `FEC_OFF_STAT) begin
				if (gated_ok) begin
					avs_readdata_o[`FEC_STAT_ERR] <= flash_error_flag_q;
				end
			end else if (avs_address_i == `FEC_OFF_EBS) begin
				if (gated_ok) begin
					avs_readdata_o[4:0] <= erase_block_select_q;
				end
			end else if (avs_address_i == `FEC_OFF_ACC) begin
				avs_readdata_o[`FEC_ACC_EN] <= ctrl_reg_access_bit_q;
			end else if (avs_address_i == `FEC_OFF_IRQ_STAT) begin
				avs_readdata_o[2:0] <= irq_stat_q;
			end else if (avs_address_i == `FEC_OFF_IRQ_MASK) begin
				avs_readdata_o[2:0] <= irq_mask_q;
			end else if (avs_address_i == `FEC_OFF_BOOT) begin
				avs_readdata_o[3:0] <= {boot_abort, boot_run_o, boot_mode, user_mode_o};
			end
		end
	end

	// strap capture at reset end; board keeps straps stable before release
	fec_mode_sel u_mode (
		.clk_i                   (clk_i),
		.rst_i                   (rst_i),
		.test_i                  (test_i),
		.nmi_i                   (nmi_i),
		.timer_port_select_pin_i (timer_port_select_pin_i),
		.user_mode_o             (user_mode_o),
		.boot_mode_o             (boot_mode),
		.done_o                  (mode_done)
	);

	// boot sequence starts only when boot straps seen
	fec_boot_seq u_boot (
		.clk_i         (clk_i),
		.rst_i         (rst_i),
		.start_i       (mode_done && boot_mode),
		.load_done_i   (boot_load_done_i),
		.erase_done_i  (flash_done_i),
		.erase_fail_i  (flash_fail_i),
		.load_active_o (boot_load_o),
		.erase_all_o   (erase_all_o),
		.run_o         (boot_run_o),
		.abort_o       (boot_abort)
	);
endmodule

// *** tb/fec_top_assertions.sv ***
// port checker for the flash control block
`timescale 1ns/1ps
module fec_top_assertions (
	// clock and reset
	input logic        clk_i,
	input logic        rst_i,
	// bus
	input logic [3:0]  avs_address_i,
	input logic        avs_read_i,
	input logic        avs_write_i,
	input logic [31:0] avs_writedata_i,
	input logic [3:0]  avs_byteenable_i,
	input logic [31:0] avs_readdata_o,
	input logic        avs_waitrequest_o,
	// straps and flash side
	input logic        test_i,
	input logic        nmi_i,
	input logic        erase_mode_o,
	input logic [4:0]  erase_sel_o,
	input logic        user_mode_o
);
	reg  acc_q; // shadow of the access bit
	wire done_w = !avs_waitrequest_o && (avs_read_i || avs_write_i); // bus cycle ends

	// shadow only follows completed low-byte writes
	always @(posedge clk_i)
		if (rst_i)
			acc_q <= 1'b0;
		else if (avs_write_i && done_w && avs_address_i == 4'h3 && avs_byteenable_i[0])
			acc_q <= avs_writedata_i[7];

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// a read finishing at a given register
	sequence s_rd(logic [3:0] a);
		avs_read_i && done_w && avs_address_i == a;
	endsequence

	a_stat_rsvd_zero: assert property (s_rd(4'h1) |-> avs_readdata_o[6:0] == 7'h00)
		else $error("status reserved bits not zero");
	a_ebs_rsvd_zero: assert property (s_rd(4'h2) |-> avs_readdata_o[7:5] == 3'h0)
		else $error("block select reserved bits not zero");
	a_acc_rsvd_zero: assert property (s_rd(4'h3) |-> avs_readdata_o[6:0] == 7'h00)
		else $error("access reserved bits not zero");
	a_gate_reads_zero: assert property (avs_read_i && done_w && avs_address_i < 4'h3 && !acc_q
		|-> avs_readdata_o[7:0] == 8'h00)
		else $error("gated register readable while closed");
	a_sel_one_hot: assert property ($onehot0(erase_sel_o))
		else $error("more than one block selected");
	a_sel_change_cause: assert property (!$stable(erase_sel_o) |-> $past(avs_write_i && done_w
		&& acc_q && avs_address_i[3:2] == 2'h0 && !avs_address_i[0]))
		else $error("block select changed without a write");
	a_erase_entry_cause: assert property ($rose(erase_mode_o) |-> $past(avs_write_i && done_w
		&& acc_q && avs_address_i == 4'h0 && avs_writedata_i[1]))
		else $error("erase mode entered without erase bit write");
	a_mode_pick_user: assert property ($fell(rst_i) |-> ##1 user_mode_o == (!test_i && nmi_i))
		else $error("user mode differs from straps");
endmodule
bind fec_top fec_top_assertions i_chk (.*);

// *** tb/fec_top_bench.sv ***
// self-checking bench for the flash control block
`timescale 1ns/1ps
module fec_top_bench;
	logic        clk_i, rst_i, avs_read_i, avs_write_i, test_i, nmi_i;
	logic        timer_port_select_pin_i, flash_fail_i, flash_done_i, boot_load_done_i;
	logic [3:0]  avs_address_i, avs_byteenable_i;
	logic [31:0] avs_writedata_i;
	wire  [31:0] avs_readdata_o;
	wire         avs_waitrequest_o, erase_mode_o, program_mode_o, erase_all_o;
	wire         boot_load_o, boot_run_o, user_mode_o, irq_o;
	wire  [4:0]  erase_sel_o;
	int          errors, cmp_count, k;
	logic [7:0]  exp_q[$]; // expected read data, oldest first
	logic [7:0]  v;

	fec_top i_dut (.*);

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		cmp_count++;
		if (seen !== want) begin
			errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask

	// request held until waitrequest is seen low at an edge
	task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
		avs_address_i <= a;
		avs_writedata_i <= {24'($urandom), d};
		avs_write_i <= w;
		avs_read_i <= !w;
		@(posedge clk_i);
		while (avs_waitrequest_o !== 1'b0) @(posedge clk_i);
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
		@(posedge clk_i);
	endtask

	task rd(input logic [3:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 8'h00);
	endtask

	// straps settle long before reset release
	task rst_run(input logic t, input logic n, input logic p);
		test_i <= t;
		nmi_i <= n;
		timer_port_select_pin_i <= p;
		rst_i <= 1'b1;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
	endtask

	task results();
		$display("comparisons %0d errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// read data taken at the edge that ends the wait
	always @(posedge clk_i)
		if (avs_read_i && !avs_waitrequest_o)
			check(avs_readdata_o[7:0], exp_q.pop_front());

	initial begin
		repeat (3000) @(posedge clk_i);
		errors++;
		results();
	end

	initial begin
		errors = 0; cmp_count = 0; rst_i = 1'b1; avs_read_i = 1'b0; avs_write_i = 1'b0;
		avs_address_i = 4'h0; avs_writedata_i = 32'h0; avs_byteenable_i = 4'hF;
		test_i = 1'b0; nmi_i = 1'b1; timer_port_select_pin_i = 1'b0;
		flash_fail_i = 1'b0; flash_done_i = 1'b0; boot_load_done_i = 1'b0;
		v = 8'($urandom(32'hd592));
		rst_run(1'b0, 1'b1, 1'b0);
		// gate closed: writes lost, reads zero
		bus(1'b1, 4'h2, 8'h01);
		rd(4'h3, 8'h00);
		bus(1'b1, 4'h3, 8'hFF);
		rd(4'h3, 8'h80);
		rd(4'h2, 8'h00);
		rd(4'h6, 8'h01);
		check({7'h0, user_mode_o}, 8'h01);
		// write enable clear refuses other bits
		bus(1'b1, 4'h0, 8'h3F);
		rd(4'h0, 8'h00);
		bus(1'b1, 4'h2, 8'h10);
		rd(4'h2, 8'h00);
		bus(1'b1, 4'h0, 8'h40);
		for (k = 0; k < 5; k++) begin
			bus(1'b1, 4'h2, 8'h01 << k);
			rd(4'h2, 8'h01 << k);
			check({3'h0, erase_sel_o}, 8'h01 << k);
		end
		// several bits at once wipe the register
		v = (8'($urandom) & 8'h1F) | 8'h18;
		bus(1'b1, 4'h2, v);
		check({3'h0, erase_sel_o}, 8'h00);
		bus(1'b1, 4'h2, 8'h04);
		bus(1'b1, 4'h0, 8'h00);
		rd(4'h2, 8'h00);
		bus(1'b1, 4'h1, 8'hFF);
		rd(4'h1, 8'h00);
		// erase needs write enable and setup
		bus(1'b1, 4'h0, 8'h42);
		check({7'h0, erase_mode_o}, 8'h00);
		bus(1'b1, 4'h0, 8'h60);
		bus(1'b1, 4'h0, 8'h62);
		check({7'h0, erase_mode_o}, 8'h01);
		bus(1'b1, 4'h0, 8'h60);
		check({7'h0, erase_mode_o}, 8'h00);
		// leaving erase raises an event: enable it in the mask, then clear it
		rd(4'h4, 8'h02);
		check({7'h0, irq_o}, 8'h00);
		bus(1'b1, 4'h5, 8'h07);
		check({7'h0, irq_o}, 8'h01);
		bus(1'b1, 4'h4, 8'h02);
		check({7'h0, irq_o}, 8'h00);
		rd(4'h4, 8'h00);
		bus(1'b1, 4'h5, 8'h00);
		// failed program operation: error flag, mode bits dropped
		bus(1'b1, 4'h0, 8'h71);
		check({7'h0, program_mode_o}, 8'h01);
		flash_fail_i <= 1'b1;
		@(posedge clk_i);
		flash_fail_i <= 1'b0;
		@(posedge clk_i);
		rd(4'h1, 8'h80);
		rd(4'h0, 8'h40);
		check({7'h0, program_mode_o}, 8'h00);
		// second reset with boot straps
		rst_run(1'b0, 1'b0, 1'b1);
		for (k = 0; k < 50 && boot_load_o !== 1'b1; k++) @(posedge clk_i);
		check({7'h0, boot_load_o}, 8'h01);
		check({7'h0, user_mode_o}, 8'h00);
		rd(4'h6, 8'h02);
		boot_load_done_i <= 1'b1;
		@(posedge clk_i);
		boot_load_done_i <= 1'b0;
		for (k = 0; k < 50 && erase_all_o !== 1'b1; k++) @(posedge clk_i);
		check({7'h0, erase_all_o}, 8'h01);
		check({7'h0, boot_run_o}, 8'h00);
		flash_done_i <= 1'b1;
		@(posedge clk_i);
		flash_done_i <= 1'b0;
		for (k = 0; k < 50 && boot_run_o !== 1'b1; k++) @(posedge clk_i);
		check({7'h0, boot_run_o}, 8'h01);
		results();
	end
endmodule
